// File: src/otpstr_fuse_array.sv
// Fuse array model: 40 fuses, timed sense and burn
`timescale 1ns/10ps
module otpstr_fuse_array
(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  // Operation requests, one-cycle pulses
  input  wire logic                              go_refresh,
  input  wire logic                              go_program,
  input  wire logic [otpstr_pkg::NV_BITS-1:0]    burn_word,
  // Results
  output logic      [otpstr_pkg::NV_BITS-1:0]    sense_word,
  output logic                                   lock_state,
  output logic                                   op_done
);

  logic [otpstr_pkg::NV_BITS-1:0] fuse;
  logic [otpstr_pkg::TIMER_W-1:0] timer;
  logic                           running;
  logic                           burning;

  wire timer_end = running && (timer == '0);

  // Fuses only ever blow; only reset returns a blown fuse to NV_BLANK
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      fuse <= otpstr_pkg::NV_BLANK;
    else if (timer_end && burning)
      fuse <= fuse | burn_word;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      running <= 1'b0;
      burning <= 1'b0;
      timer   <= '0;
    end
    else if (go_refresh || go_program)
    begin
      running <= 1'b1;
      burning <= go_program;
      timer   <= go_program ? otpstr_pkg::TIMER_W'(otpstr_pkg::PROG_CYCLES - 1)
                            : otpstr_pkg::TIMER_W'(otpstr_pkg::REFRESH_CYCLES - 1);
    end
    else if (timer_end)
      running <= 1'b0;
    else if (running)
      timer <= timer - 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sense_word <= '0;
      op_done    <= 1'b0;
    end
    else
    begin
      op_done <= timer_end;
      if (timer_end && !burning)
        sense_word <= fuse;
    end
  end

  assign lock_state = fuse[otpstr_pkg::NV_LOCK_BIT];

  a_burn_sets_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    (timer_end && burning && burn_word[otpstr_pkg::NV_LOCK_BIT]) |=> lock_state)
    else $error("lock fuse not blown by program");

endmodule : otpstr_fuse_array

// File: src/otpstr_pkg.sv
// Package: constants, register map and carrier types for the one-time store and trim readback
package otpstr_pkg;

  // Clock and operation timing
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int REFRESH_TIME_NS = 1000;
  localparam int PROG_TIME_US    = 100;
  localparam int REFRESH_CYCLES  = (REFRESH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROG_CYCLES     = (PROG_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TIMER_W         = 12;

  // Store geometry
  localparam int NV_BITS      = 40;
  localparam int NV_LOCK_BIT  = 39;
  localparam int WIN_W        = 10;
  localparam logic [NV_BITS-1:0] NV_BLANK = 40'h00_0000_0000;

  // Register offsets
  localparam logic [4:0] ADDR_DIAG_LATCH = 5'h16;
  localparam logic [4:0] ADDR_STATUS     = 5'h17;
  localparam logic [4:0] ADDR_TRIM_RANGE = 5'h18;
  localparam logic [4:0] ADDR_DELTA_LOW  = 5'h19;
  localparam logic [4:0] ADDR_DELTA_HIGH = 5'h1A;
  localparam logic [4:0] ADDR_TEMPCO_C1  = 5'h1B;
  localparam logic [4:0] ADDR_TEMPCO_C2  = 5'h1C;
  localparam logic [4:0] ADDR_TEMPCO_SP  = 5'h1D;
  localparam logic [4:0] ADDR_NV_WINDOW  = 5'h1E;
  localparam logic [4:0] ADDR_REVISION   = 5'h1F;

  // Field positions
  localparam int PARITY_BIT    = 8;
  localparam int DIAG_FAIL_BIT = 7;
  localparam int ST_ACTIVE_BIT = 4;
  localparam int ST_C1_SHORT   = 3;
  localparam int ST_C2_SHORT   = 2;
  localparam int ST_C1_RUN     = 1;
  localparam int ST_C2_RUN     = 0;

  // Store commands
  localparam logic [1:0] CMD_NOP_LOW  = 2'h0;
  localparam logic [1:0] CMD_REFRESH  = 2'h1;
  localparam logic [1:0] CMD_PROGRAM  = 2'h2;
  localparam logic [1:0] CMD_NOP_HIGH = 2'h3;

  // Revision code: arbitrary neutral values
  localparam logic [1:0] REV_FULL_MASK = 2'h0;
  localparam logic [1:0] REV_METAL     = 2'h0;
  localparam logic       REV_TOP_BIT   = 1'b1;

  typedef enum logic [2:0] {
    OTPSTR_IDLE    = 3'b001,
    OTPSTR_REFRESH = 3'b010,
    OTPSTR_PROGRAM = 3'b100
  } otpstr_state_e;

  // Packed so that the struct is the store word below the lock bit
  typedef struct packed {
    logic [1:0] overcurrent_period_count;
    logic       chan2_thermal_autorecover;
    logic       chan1_thermal_autorecover;
    logic [2:0] failsafe_config;
    logic       chan2_enable;
    logic       chan1_enable;
    logic [4:0] chan2_off_time;
    logic [4:0] chan1_off_time;
    logic [1:0] chan2_sense_range;
    logic [7:0] chan2_voltage_threshold;
    logic [1:0] chan1_sense_range;
    logic [7:0] chan1_voltage_threshold;
  } otpstr_cfg_s;

  typedef struct packed {
    logic [6:0] peak_trim_range;
    logic [3:0] peak_trim_delta_four;
    logic [3:0] peak_trim_delta_three;
    logic [3:0] peak_trim_delta_two;
    logic [3:0] peak_trim_delta_one;
    logic [3:0] tempco_high_ranges;
    logic [3:0] tempco_low_ranges;
  } otpstr_trim_s;

  // Odd parity: bit makes the total count of ones odd
  function automatic logic otpstr_odd_parity(input logic [7:0] bits);
    otpstr_odd_parity = ~(^bits);
  endfunction : otpstr_odd_parity

  function automatic logic [9:0] otpstr_trim_word(input logic [7:0] bits);
    otpstr_trim_word = {1'b0, otpstr_odd_parity(bits), bits};
  endfunction : otpstr_trim_word

endpackage : otpstr_pkg

// File: src/otpstr_top.sv
// Store sequencer, status flags and read-only register readback
`timescale 1ns/10ps
module otpstr_top
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // Register read port from the serial interface
  input  wire logic                     rd_en,
  input  wire logic [4:0]               rd_addr,
  output logic      [9:0]               rd_data,
  output logic                          rd_valid,
  // Store control fields from the writable register file
  input  wire logic                     cmd_wr,
  input  wire logic [1:0]               cmd,
  input  wire logic [1:0]               win_sel,
  input  wire logic                     bank_sel,
  input  wire otpstr_pkg::otpstr_cfg_s  cfg,
  // Factory trim constants
  input  wire otpstr_pkg::otpstr_trim_s trim_c1,
  input  wire otpstr_pkg::otpstr_trim_s trim_c2,
  // Analog monitors and regulator state
  input  wire logic                     program_supply_undervoltage,
  input  wire logic                     chan1_short_on_evt,
  input  wire logic                     chan2_short_on_evt,
  input  wire logic                     chan1_enabled,
  input  wire logic                     chan2_enabled,
  // Status
  output logic                          nv_busy,
  output logic                          nv_locked,
  output logic                          program_failed
);

  otpstr_pkg::otpstr_state_e state;
  otpstr_pkg::otpstr_state_e next_state;

  logic [otpstr_pkg::NV_BITS-1:0] sense_word;
  logic [otpstr_pkg::NV_BITS-1:0] shadow;
  logic                           lock_state;
  logic                           op_done;
  logic                           chan1_short_on_flag;
  logic                           chan2_short_on_flag;
  logic                           chan1_running;
  logic                           chan2_running;
  logic                           next_busy;
  logic                           next_fail;
  logic                           next_c1_short;
  logic                           next_c2_short;
  logic [9:0]                     next_rd_data;
  logic [otpstr_pkg::TIMER_W-1:0] busy_len;

  // Command decode
  wire idle        = (state == otpstr_pkg::OTPSTR_IDLE);
  wire want_fresh  = cmd_wr && (cmd == otpstr_pkg::CMD_REFRESH);
  wire want_burn   = cmd_wr && (cmd == otpstr_pkg::CMD_PROGRAM);
  wire go_refresh  = idle && want_fresh;
  wire go_program  = idle && want_burn && !lock_state;
  wire in_program  = (state == otpstr_pkg::OTPSTR_PROGRAM);

  // Burn word is the live configuration plus the lock fuse
  wire [otpstr_pkg::NV_BITS-1:0] burn_word = {1'b1, cfg};

  // Read decode
  wire rd_diag   = rd_en && (rd_addr == otpstr_pkg::ADDR_DIAG_LATCH);
  wire rd_status = rd_en && (rd_addr == otpstr_pkg::ADDR_STATUS);

  otpstr_fuse_array u_fuse
  (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .go_refresh (go_refresh),
    .go_program (go_program),
    .burn_word  (burn_word),
    .sense_word (sense_word),
    .lock_state (lock_state),
    .op_done    (op_done)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      otpstr_pkg::OTPSTR_IDLE:
      begin
        if (go_program)
          next_state = otpstr_pkg::OTPSTR_PROGRAM;
        else if (go_refresh)
          next_state = otpstr_pkg::OTPSTR_REFRESH;
      end
      otpstr_pkg::OTPSTR_REFRESH:
      begin
        if (op_done)
          next_state = otpstr_pkg::OTPSTR_IDLE;
      end
      otpstr_pkg::OTPSTR_PROGRAM:
      begin
        if (op_done)
          next_state = otpstr_pkg::OTPSTR_IDLE;
      end
      default:
        next_state = otpstr_pkg::OTPSTR_IDLE;
    endcase
  end

  // Flag updates: a new event beats a same-cycle clearing read
  assign next_busy     = (next_state != otpstr_pkg::OTPSTR_IDLE);
  assign next_fail     = (in_program && program_supply_undervoltage)
                         || (program_failed && !rd_diag);
  assign next_c1_short = chan1_short_on_evt || (chan1_short_on_flag && !rd_status);
  assign next_c2_short = chan2_short_on_evt || (chan2_short_on_flag && !rd_status);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state               <= otpstr_pkg::OTPSTR_IDLE;
      nv_busy             <= 1'b0;
      program_failed      <= 1'b0;
      chan1_short_on_flag <= 1'b0;
      chan2_short_on_flag <= 1'b0;
      chan1_running       <= 1'b0;
      chan2_running       <= 1'b0;
      nv_locked           <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      nv_busy             <= next_busy;
      program_failed      <= next_fail;
      chan1_short_on_flag <= next_c1_short;
      chan2_short_on_flag <= next_c2_short;
      chan1_running       <= chan1_enabled;
      chan2_running       <= chan2_enabled;
      nv_locked           <= lock_state;
    end
  end

  // Window only changes when a refresh finishes, never mid-operation
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      shadow <= '0;
    else if (op_done && (state == otpstr_pkg::OTPSTR_REFRESH))
      shadow <= sense_word;
  end

  // Trim banks; factory values arrive on the trim inputs
  wire otpstr_pkg::otpstr_trim_s trim_bank = bank_sel ? trim_c2 : trim_c1;

  wire [7:0] range_bits  = {1'b0, trim_bank.peak_trim_range};
  wire [7:0] dlow_bits   = {trim_bank.peak_trim_delta_two,
                            trim_bank.peak_trim_delta_one};
  wire [7:0] dhigh_bits  = {trim_bank.peak_trim_delta_four,
                            trim_bank.peak_trim_delta_three};
  wire [7:0] tc1_bits    = {trim_c1.tempco_high_ranges, trim_c1.tempco_low_ranges};
  wire [7:0] tc2_bits    = {trim_c2.tempco_high_ranges, trim_c2.tempco_low_ranges};

  wire [9:0] window_word = shadow[win_sel * otpstr_pkg::WIN_W +: otpstr_pkg::WIN_W];

  wire [9:0] status_word = {5'h00, nv_busy, chan1_short_on_flag, chan2_short_on_flag,
                            chan1_running, chan2_running};
  wire [7:0] status_bits = status_word[7:0];
  wire [7:0] diag_bits   = {program_failed, 7'h00};

  wire [8:0] revision_code = {otpstr_pkg::REV_TOP_BIT, 3'h0, otpstr_pkg::REV_FULL_MASK,
                              1'b0, otpstr_pkg::REV_METAL};

  always_comb
  begin
    case (rd_addr)
      otpstr_pkg::ADDR_DIAG_LATCH: next_rd_data = otpstr_pkg::otpstr_trim_word(diag_bits);
      otpstr_pkg::ADDR_STATUS:     next_rd_data = otpstr_pkg::otpstr_trim_word(status_bits);
      otpstr_pkg::ADDR_TRIM_RANGE: next_rd_data = otpstr_pkg::otpstr_trim_word(range_bits);
      otpstr_pkg::ADDR_DELTA_LOW:  next_rd_data = otpstr_pkg::otpstr_trim_word(dlow_bits);
      otpstr_pkg::ADDR_DELTA_HIGH: next_rd_data = otpstr_pkg::otpstr_trim_word(dhigh_bits);
      otpstr_pkg::ADDR_TEMPCO_C1:  next_rd_data = otpstr_pkg::otpstr_trim_word(tc1_bits);
      otpstr_pkg::ADDR_TEMPCO_C2:  next_rd_data = otpstr_pkg::otpstr_trim_word(tc2_bits);
      otpstr_pkg::ADDR_TEMPCO_SP:  next_rd_data = 10'h000;
      otpstr_pkg::ADDR_NV_WINDOW:  next_rd_data = window_word;
      otpstr_pkg::ADDR_REVISION:   next_rd_data = {1'b0, revision_code};
      default:                     next_rd_data = 10'h000;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data  <= 10'h000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= next_rd_data;
    end
  end

  // Busy cycle count; feeds only the length check, one small counter
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      busy_len <= '0;
    else if (nv_busy)
      busy_len <= busy_len + 1'b1;
    else
      busy_len <= '0;
  end

  // Checks
  a_busy_on_start: assert property (@(posedge core_clk) disable iff (!resetn)
    (idle && want_fresh) |=> nv_busy ##1 nv_busy)
    else $error("busy not raised for refresh");

  a_busy_drops_done: assert property (@(posedge core_clk) disable iff (!resetn)
    (op_done && !cmd_wr) |=> !nv_busy)
    else $error("busy stays after operation end");

  a_busy_length: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(nv_busy) |-> busy_len == ($past(in_program)
      ? otpstr_pkg::TIMER_W'(otpstr_pkg::PROG_CYCLES + 1)
      : otpstr_pkg::TIMER_W'(otpstr_pkg::REFRESH_CYCLES + 1)))
    else $error("busy length wrong");

  a_refresh_bounded: assert property (@(posedge core_clk) disable iff (!resetn)
    go_refresh |-> ##[40:43] op_done)
    else $error("refresh length wrong");

  a_short_latch: assert property (@(posedge core_clk) disable iff (!resetn)
    chan1_short_on_evt |=> chan1_short_on_flag)
    else $error("short flag not latched");

  a_short_clear_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_status && !chan2_short_on_evt) |=> !chan2_short_on_flag)
    else $error("short flag not cleared by read");

  a_running_read: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_status && $past(resetn)) |=>
      (rd_data[otpstr_pkg::ST_C1_RUN] == $past(chan1_enabled, 2))
      && (rd_data[otpstr_pkg::ST_C2_RUN] == $past(chan2_enabled, 2)))
    else $error("running bit wrong");

  a_bank_range: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_en && rd_addr == otpstr_pkg::ADDR_TRIM_RANGE) |=>
      rd_data[6:0] == $past(bank_sel ? trim_c2.peak_trim_range : trim_c1.peak_trim_range)
      && !rd_data[7] && !rd_data[9])
    else $error("range trim readback wrong");

  a_trim_parity: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_en && rd_addr >= otpstr_pkg::ADDR_TRIM_RANGE && rd_addr <= otpstr_pkg::ADDR_TEMPCO_C2)
      |=> (^rd_data[8:0]) && !rd_data[9])
    else $error("trim parity wrong");

  a_window_pick: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_en && rd_addr == otpstr_pkg::ADDR_NV_WINDOW) |=>
      rd_data == $past(shadow[win_sel * otpstr_pkg::WIN_W +: otpstr_pkg::WIN_W]))
    else $error("window slice wrong");

  a_revision_word: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_en && rd_addr == otpstr_pkg::ADDR_REVISION) |=> !rd_data[9] && rd_data[8])
    else $error("revision word wrong");

  a_locked_no_burn: assert property (@(posedge core_clk) disable iff (!resetn)
    (want_burn && lock_state) |=> !in_program)
    else $error("program started while locked");

  a_fail_latch: assert property (@(posedge core_clk) disable iff (!resetn)
    (in_program && program_supply_undervoltage) |=> program_failed [*2] or
      (program_failed ##1 $past(rd_diag)))
    else $error("program failure not latched");

  c_refresh_read: cover property (@(posedge core_clk) disable iff (!resetn)
    go_refresh ##[40:45] (rd_en && rd_addr == otpstr_pkg::ADDR_NV_WINDOW));

  c_program_done: cover property (@(posedge core_clk) disable iff (!resetn)
    in_program && op_done);

  c_short_set_clear: cover property (@(posedge core_clk) disable iff (!resetn)
    chan1_short_on_evt && rd_status);

  c_locked_refused: cover property (@(posedge core_clk) disable iff (!resetn)
    want_burn && lock_state);

  c_top_window: cover property (@(posedge core_clk) disable iff (!resetn)
    rd_en && (rd_addr == otpstr_pkg::ADDR_NV_WINDOW) && (win_sel == 2'h3));

endmodule : otpstr_top

// File: tb/otpstr_host_model.sv
// Host-side model: drives register reads and store commands, notes expected read data
`timescale 1ns/10ps
module otpstr_host_model
(
  // Clock
  input  wire logic                core_clk,
  // Register port toward the device
  output logic                     rd_en,
  output logic [4:0]               rd_addr,
  output logic                     cmd_wr,
  output logic [1:0]               cmd,
  output logic [1:0]               win_sel,
  output logic                     bank_sel,
  output otpstr_pkg::otpstr_cfg_s  cfg
);
  logic [9:0] exp_q[$];

  initial
  begin
    rd_en    = 1'b0;
    rd_addr  = 5'h00;
    cmd_wr   = 1'b0;
    cmd      = 2'h0;
    win_sel  = 2'h0;
    bank_sel = 1'b0;
    cfg      = '0;
  end

  task automatic read_reg(input logic [4:0] addr, input logic [9:0] exp);
    @(negedge core_clk);
    rd_en   = 1'b1;
    rd_addr = addr;
    exp_q.push_back(exp);
    @(negedge core_clk);
    rd_en   = 1'b0;
    // Offset lines do not hold the last value once released
    rd_addr = ~addr;
  endtask : read_reg

  task automatic issue_cmd(input logic [1:0] c);
    @(negedge core_clk);
    cmd_wr = 1'b1;
    cmd    = c;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    cmd    = ~c;
  endtask : issue_cmd

  // Configuration first, then one single program write
  task automatic program_store(input otpstr_pkg::otpstr_cfg_s c);
    @(negedge core_clk);
    cfg = c;
    issue_cmd(otpstr_pkg::CMD_PROGRAM);
  endtask : program_store

  task automatic set_window(input logic [1:0] w);
    win_sel = w;
  endtask : set_window

  task automatic set_bank(input logic b);
    bank_sel = b;
  endtask : set_bank
endmodule : otpstr_host_model

// File: tb/otpstr_top_tb_top.sv
// Self-checking testbench for the store sequencer and trim readback
`timescale 1ns/10ps
module otpstr_top_tb_top;
  logic                      core_clk;
  logic                      resetn;
  logic [9:0]                rd_data;
  logic                      rd_valid;
  logic                      uv;
  logic                      s1_evt;
  logic                      s2_evt;
  logic                      en1;
  logic                      en2;
  logic                      nv_busy;
  logic                      nv_locked;
  logic                      program_failed;
  otpstr_pkg::otpstr_trim_s  trim_c1;
  otpstr_pkg::otpstr_trim_s  trim_c2;
  otpstr_pkg::otpstr_trim_s  tr;
  otpstr_pkg::otpstr_cfg_s   cfg_v;
  logic [63:0]               rnd;
  logic [4:0]                rd_addr;
  logic                      rd_en;
  logic                      cmd_wr;
  logic [1:0]                cmd;
  logic [1:0]                win_sel;
  logic                      bank_sel;
  otpstr_pkg::otpstr_cfg_s   cfg;
  int                        seed;
  int                        mismatches;
  int                        compares;

  otpstr_host_model i_host (.core_clk(core_clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .cmd_wr(cmd_wr), .cmd(cmd), .win_sel(win_sel), .bank_sel(bank_sel), .cfg(cfg));

  otpstr_top i_dut (.core_clk(core_clk), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .cmd_wr(cmd_wr), .cmd(cmd), .win_sel(win_sel),
    .bank_sel(bank_sel), .cfg(cfg), .trim_c1(trim_c1), .trim_c2(trim_c2),
    .program_supply_undervoltage(uv), .chan1_short_on_evt(s1_evt),
    .chan2_short_on_evt(s2_evt), .chan1_enabled(en1), .chan2_enabled(en2),
    .nv_busy(nv_busy), .nv_locked(nv_locked), .program_failed(program_failed));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [9:0] tw(input logic [7:0] b);
    tw = {1'b0, ~(^b), b};
  endfunction : tw

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Watches read answers against the oldest note
  always @(negedge core_clk)
    if (rd_valid === 1'b1)
    begin
      if (i_host.exp_q.size() == 0)
        check("unexpected rd_valid", 10'h001, 10'h000);
      else
        check("rd_data", rd_data, i_host.exp_q.pop_front());
    end

  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 5000)
    begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_idle

  task automatic run_op(input logic [1:0] c, input logic busy_exp);
    i_host.issue_cmd(c);
    @(negedge core_clk);
    check("nv_busy", nv_busy, busy_exp);
    wait_idle();
  endtask : run_op

  // Margin bits are not modelled; two identical passes stand in for both margins
  task automatic verify_store(input logic [39:0] w);
    for (int m = 0; m < 2; m++)
    begin
      run_op(otpstr_pkg::CMD_REFRESH, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
        i_host.set_window(k[1:0]);
        i_host.read_reg(otpstr_pkg::ADDR_NV_WINDOW, w[10*k +: 10]);
      end
    end
  endtask : verify_store

  initial
  begin
    seed = 32'ha5e1;
    mismatches = 0;
    compares = 0;
    {uv, s1_evt, s2_evt, en1, en2} = 5'h00;
    rnd = {$random(seed), $random(seed)};
    trim_c1 = rnd[30:0];
    trim_c1.peak_trim_delta_one = 4'h8;
    trim_c1.peak_trim_delta_two = 4'h7;
    trim_c2 = rnd[61:31];
    resetn = 1'b0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    i_host.read_reg(5'h00, 10'h000);
    i_host.read_reg(otpstr_pkg::ADDR_TEMPCO_SP, 10'h000);
    i_host.read_reg(otpstr_pkg::ADDR_NV_WINDOW, 10'h000);
    i_host.read_reg(otpstr_pkg::ADDR_STATUS, tw(8'h00));
    i_host.read_reg(otpstr_pkg::ADDR_REVISION, {1'b0, otpstr_pkg::REV_TOP_BIT, 3'h0,
      otpstr_pkg::REV_FULL_MASK, 1'b0, otpstr_pkg::REV_METAL});
    for (int b = 0; b < 2; b++)
    begin
      i_host.set_bank(b[0]);
      tr = b[0] ? trim_c2 : trim_c1;
      i_host.read_reg(otpstr_pkg::ADDR_TRIM_RANGE, tw({1'b0, tr.peak_trim_range}));
      i_host.read_reg(otpstr_pkg::ADDR_DELTA_LOW,
        tw({tr.peak_trim_delta_two, tr.peak_trim_delta_one}));
      i_host.read_reg(otpstr_pkg::ADDR_DELTA_HIGH,
        tw({tr.peak_trim_delta_four, tr.peak_trim_delta_three}));
    end
    i_host.read_reg(otpstr_pkg::ADDR_TEMPCO_C1,
      tw({trim_c1.tempco_high_ranges, trim_c1.tempco_low_ranges}));
    i_host.read_reg(otpstr_pkg::ADDR_TEMPCO_C2,
      tw({trim_c2.tempco_high_ranges, trim_c2.tempco_low_ranges}));
    en1 = 1'b1;
    s2_evt = 1'b1;
    @(negedge core_clk);
    s2_evt = 1'b0;
    i_host.read_reg(otpstr_pkg::ADDR_STATUS, tw(8'h06));
    i_host.read_reg(otpstr_pkg::ADDR_STATUS, tw(8'h02));
    en1 = 1'b0;
    en2 = 1'b1;
    s1_evt = 1'b1;
    @(negedge core_clk);
    s1_evt = 1'b0;
    i_host.read_reg(otpstr_pkg::ADDR_STATUS, tw(8'h09));
    run_op(otpstr_pkg::CMD_NOP_LOW, 1'b0);
    run_op(otpstr_pkg::CMD_NOP_HIGH, 1'b0);
    i_host.issue_cmd(otpstr_pkg::CMD_REFRESH);
    i_host.read_reg(otpstr_pkg::ADDR_STATUS, tw(8'h11));
    // A program write during a refresh is dropped
    i_host.issue_cmd(otpstr_pkg::CMD_PROGRAM);
    wait_idle();
    check("nv_locked", nv_locked, 1'b0);
    verify_store(40'h00_0000_0000);
    rnd = {$random(seed), $random(seed)};
    cfg_v = rnd[38:0];
    uv = 1'b1;
    i_host.program_store(cfg_v);
    @(negedge core_clk);
    check("nv_busy", nv_busy, 1'b1);
    wait_idle();
    uv = 1'b0;
    check("program_failed", program_failed, 1'b1);
    check("nv_locked", nv_locked, 1'b1);
    i_host.read_reg(otpstr_pkg::ADDR_DIAG_LATCH, tw(8'h80));
    i_host.read_reg(otpstr_pkg::ADDR_DIAG_LATCH, tw(8'h00));
    verify_store({1'b1, cfg_v});
    i_host.program_store(~cfg_v);
    @(negedge core_clk);
    check("nv_busy", nv_busy, 1'b0);
    verify_store({1'b1, cfg_v});
    repeat (4) @(negedge core_clk);
    check("pending reads", 10'(i_host.exp_q.size()), 10'h000);
    give_verdict();
  end
endmodule : otpstr_top_tb_top
